// ===== core/ssp_pkg.sv
// constants, encodings and state types of the synchronous serial port
package ssp_pkg;

  // ************************************************************
  // register byte addresses
  // ************************************************************
  localparam logic [5:0] ADDR_CONTROL_ONE = 6'h00;
  localparam logic [5:0] ADDR_CONTROL_TWO = 6'h04;
  localparam logic [5:0] ADDR_STATUS      = 6'h08;
  localparam logic [5:0] ADDR_BUFFER_BASE = 6'h20;
  localparam int         BUFFER_WORDS     = 8;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int START_POS    = 7;
  localparam int ABORT_POS    = 6;
  localparam int MODE_LSB     = 3;
  localparam int CLKSEL_LSB   = 0;
  localparam int BASESEL_POS  = 5;
  localparam int WAITCTL_LSB  = 3;
  localparam int COUNT_LSB    = 0;
  localparam int BUSY_POS     = 7;
  localparam int SHIFTING_POS = 6;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] CONTROL_ONE_RESET = 8'h00;
  localparam logic [7:0] CONTROL_TWO_RESET = 8'h00;

  // ************************************************************
  // transfer modes and clock sources
  // ************************************************************
  localparam logic [2:0] MODE_TX8   = 3'h0;
  localparam logic [2:0] MODE_TX4   = 3'h1;
  localparam logic [2:0] MODE_TXRX8 = 3'h2;
  localparam logic [2:0] MODE_RX8   = 3'h5;
  localparam logic [2:0] MODE_RX4   = 3'h6;

  localparam logic [2:0] CLK_INT_MAX  = 3'h5;
  localparam logic [2:0] CLK_RESERVED = 3'h6;
  localparam logic [2:0] CLK_EXTERNAL = 3'h7;

  // divider exponents: serial period is 2**exp system clocks
  localparam int DIV_EXP_SLOW0 = 13;
  localparam int DIV_EXP_BASE1 = 10;
  localparam int DIV_EXP_C1    = 8;
  localparam int DIV_EXP_C2    = 7;
  localparam int DIV_EXP_C3    = 6;
  localparam int DIV_EXP_C4    = 5;
  localparam int DIV_EXP_C5    = 4;
  localparam int DIV_WIDTH     = 13;

  localparam logic [7:0] DUMMY_WORD = 8'hFF;

  typedef enum logic [1:0] {
    SSP_IDLE  = 2'b00,
    SSP_SHIFT = 2'b01,
    SSP_STALL = 2'b10
  } ssp_state_type;

endpackage

// ===== core/ssp_port.sv
// synchronous serial port with avalon register slave
`timescale 1ns/1ps

// ************************************************************
// Overview of operation
// - codes 0-5 internal, 6 reserved, 7 external
// - internal clock drives pin, high at start
// - internal clock stalls until software services
// - transmit on falling, receive on rising
// - four-bit mode uses low nibble, zeroes high
// - words shift least significant bit first
// - burst of one to eight words, then irq
// - next word prefetched after first bit out
// - transmit irq after last word sent
// - transmit stall released by any buffer write
// - writes to unused buffers also release stall
// - start cleared: transmit-only modes finish burst, then drop busy
// - abort ends transfer and busy at once
// - external transmit without data sends dummy
// - receive stores words, irq when buffers full
// - receive stall released by any buffer read
// - reads of unused buffers also release stall
// - external receive overrun drops word, stops
// - receive stop finishes word; abort discards
// - mode change clears buffer contents
// - count n selects n+1 lowest buffers
// - busy falls at end or on abort
// ************************************************************
module ssp_port (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        sck_in,
  output logic             sck_out,
  output logic             sck_oe_n,
  output logic             so_out,
  input  wire logic        si_in,
  output logic             serial_done_irq,
  output logic             transfer_busy_flag
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic                          start;
    logic [2:0]                    mode;
    logic [2:0]                    clksel;
    logic                          base_sel;
    logic [1:0]                    wait_ctl;
    logic [2:0]                    count;
    logic [7:0][7:0]               bufs;
    logic                          pending;
    logic                          reload;
    logic                          dummy;
    logic [2:0]                    idx;
    logic [2:0]                    bitcnt;
    logic [7:0]                    shreg;
    logic [7:0]                    pre;
    logic                          sck;
    logic                          sck_prev;
    logic                          so;
    logic                          sck_drive;
    logic                          busy;
    logic                          shifting;
    logic                          irq;
    logic [ssp_pkg::DIV_WIDTH-1:0] div;
    ssp_pkg::ssp_state_type        state;
    logic                          waitreq;
    logic [31:0]                   rdata;
  } ssp_regs_type;

  ssp_regs_type s_r;
  ssp_regs_type s_nxt;

  logic sck_sync;
  logic si_sync;

  ssp_sync3 u_sync_sck (
    .clk       (clk),
    .reset_n   (reset_n),
    .pin_in    (sck_in),
    .level_out (sck_sync)
  );

  ssp_sync3 u_sync_si (
    .clk       (clk),
    .reset_n   (reset_n),
    .pin_in    (si_in),
    .level_out (si_sync)
  );

  // ************************************************************
  // decode helpers
  // ************************************************************
  function automatic logic mode_tx(input logic [2:0] m);
    return (m == ssp_pkg::MODE_TX8) || (m == ssp_pkg::MODE_TX4) ||
           (m == ssp_pkg::MODE_TXRX8);
  endfunction

  function automatic logic mode_rx(input logic [2:0] m);
    return (m == ssp_pkg::MODE_RX8) || (m == ssp_pkg::MODE_RX4) ||
           (m == ssp_pkg::MODE_TXRX8);
  endfunction

  function automatic logic mode_four(input logic [2:0] m);
    return (m == ssp_pkg::MODE_TX4) || (m == ssp_pkg::MODE_RX4);
  endfunction

  // half period mask of the free divider for each internal code
  function automatic logic [ssp_pkg::DIV_WIDTH-1:0] div_mask(
    input logic [2:0] sel,
    input logic       base
  );
    int e;
    e = ssp_pkg::DIV_EXP_C5;
    unique case (sel)
      3'h0: e = base ? ssp_pkg::DIV_EXP_BASE1 : ssp_pkg::DIV_EXP_SLOW0;
      3'h1: e = ssp_pkg::DIV_EXP_C1;
      3'h2: e = ssp_pkg::DIV_EXP_C2;
      3'h3: e = ssp_pkg::DIV_EXP_C3;
      3'h4: e = ssp_pkg::DIV_EXP_C4;
      default: e = ssp_pkg::DIV_EXP_C5;
    endcase
    return ssp_pkg::DIV_WIDTH'((1 << (e - 1)) - 1);
  endfunction

  // ************************************************************
  // next state
  // ************************************************************
  logic       internal_clk;
  logic       external_clk;
  logic       tick;
  logic       fall;
  logic       rise;
  logic       is_tx;
  logic       is_rx;
  logic       buf_hit;
  logic       buf_wr;
  logic       buf_rd;
  logic       abort;
  logic       last_bit;
  logic       last_word;
  logic [2:0] buf_idx;
  logic [7:0] sh;
  logic [7:0] src;
  logic [7:0] wdata;

  always_comb begin
    s_nxt        = s_r;
    s_nxt.irq    = 1'b0;
    s_nxt.div    = s_r.div + ssp_pkg::DIV_WIDTH'(1);
    buf_wr       = 1'b0;
    buf_rd       = 1'b0;
    abort        = 1'b0;
    sh           = {si_sync, s_r.shreg[7:1]};
    src          = s_r.bufs[0];
    wdata        = avs_writedata[7:0];
    buf_hit      = (avs_address[5] == 1'b1) && (avs_address[1:0] == 2'b00);
    buf_idx      = avs_address[4:2];
    is_tx        = mode_tx(s_r.mode);
    is_rx        = mode_rx(s_r.mode);
    internal_clk = (s_r.clksel <= ssp_pkg::CLK_INT_MAX);
    external_clk = (s_r.clksel == ssp_pkg::CLK_EXTERNAL);
    tick         = internal_clk &&
                   ((s_r.div & div_mask(s_r.clksel, s_r.base_sel)) ==
                    div_mask(s_r.clksel, s_r.base_sel));
    // reserved code makes neither edge
    fall = internal_clk ? (tick && s_r.sck)
                        : (external_clk && s_r.sck_prev && !sck_sync);
    rise = internal_clk ? (tick && !s_r.sck)
                        : (external_clk && !s_r.sck_prev && sck_sync);
    last_bit  = s_r.bitcnt == (mode_four(s_r.mode) ? 3'h3 : 3'h7);
    last_word = s_r.idx == s_r.count;
    s_nxt.sck_prev  = sck_sync;
    s_nxt.sck_drive = internal_clk;

    // avalon slave: one wait cycle, then the access completes
    if ((avs_read || avs_write) && s_r.waitreq) begin
      s_nxt.waitreq = 1'b0;
      s_nxt.rdata   = 32'h0000_0000;
      if (buf_hit) begin
        s_nxt.rdata[7:0] = s_r.bufs[buf_idx];
      end else if (avs_address == ssp_pkg::ADDR_CONTROL_ONE) begin
        s_nxt.rdata[7:0] = {s_r.start, 1'b0, s_r.mode, s_r.clksel[2:0]};
      end else if (avs_address == ssp_pkg::ADDR_CONTROL_TWO) begin
        s_nxt.rdata[7:0] = {2'b00, s_r.base_sel, s_r.wait_ctl, s_r.count};
      end else if (avs_address == ssp_pkg::ADDR_STATUS) begin
        s_nxt.rdata[ssp_pkg::BUSY_POS]     = s_r.busy;
        s_nxt.rdata[ssp_pkg::SHIFTING_POS] = s_r.shifting;
      end
    end else if (!s_r.waitreq) begin
      s_nxt.waitreq = 1'b1;
      if (avs_write && avs_byteenable[0]) begin
        if (buf_hit) begin
          s_nxt.bufs[buf_idx] = wdata;
          buf_wr = 1'b1;
        end else if (avs_address == ssp_pkg::ADDR_CONTROL_ONE) begin
          s_nxt.start  = wdata[ssp_pkg::START_POS];
          abort        = wdata[ssp_pkg::ABORT_POS];
          s_nxt.mode   = wdata[ssp_pkg::MODE_LSB +: 3];
          s_nxt.clksel = wdata[ssp_pkg::CLKSEL_LSB +: 3];
          if (wdata[ssp_pkg::MODE_LSB +: 3] != s_r.mode) begin
            s_nxt.bufs = '0;
          end
        end else if (avs_address == ssp_pkg::ADDR_CONTROL_TWO) begin
          s_nxt.base_sel = wdata[ssp_pkg::BASESEL_POS];
          s_nxt.wait_ctl = wdata[ssp_pkg::WAITCTL_LSB +: 2];
          s_nxt.count    = wdata[ssp_pkg::COUNT_LSB +: 3];
        end
      end else if (avs_read && buf_hit) begin
        buf_rd = 1'b1;
      end
    end

    // a transmit-mode write or receive-mode read of any buffer, used or not, services the port
    if ((is_tx && buf_wr) || (is_rx && buf_rd)) begin
      s_nxt.pending = 1'b0;
    end

    unique case (s_r.state)
      ssp_pkg::SSP_IDLE: begin
        s_nxt.sck      = 1'b1;
        s_nxt.busy     = 1'b0;
        s_nxt.shifting = 1'b0;
        s_nxt.pending  = 1'b0;
        if (s_r.start && (is_tx || is_rx) &&
            (s_r.clksel != ssp_pkg::CLK_RESERVED)) begin
          s_nxt.state    = ssp_pkg::SSP_SHIFT;
          s_nxt.sck      = 1'b1;
          s_nxt.busy     = 1'b1;
          s_nxt.shifting = 1'b1;
          s_nxt.idx      = 3'h0;
          s_nxt.bitcnt   = 3'h0;
          s_nxt.reload   = 1'b1;
          s_nxt.dummy    = 1'b0;
        end
      end
      ssp_pkg::SSP_SHIFT: begin
        if (tick) begin
          s_nxt.sck = !s_r.sck;
        end
        // data out changes on the falling edge
        if (fall && (s_r.bitcnt == 3'h0)) begin
          if (s_r.reload) begin
            if (external_clk && is_tx && s_r.pending) begin
              src         = ssp_pkg::DUMMY_WORD;
              s_nxt.dummy = 1'b1;
            end
            s_nxt.shreg  = src;
            s_nxt.so     = src[0];
            s_nxt.reload = 1'b0;
          end else begin
            s_nxt.so = s_r.shreg[0];
          end
          s_nxt.pre = s_r.bufs[s_r.idx + 3'h1];
        end else if (fall) begin
          s_nxt.so = s_r.shreg[0];
        end
        // data in is sampled on the rising edge
        if (rise) begin
          s_nxt.shreg  = sh;
          s_nxt.bitcnt = s_r.bitcnt + 3'h1;
          if (last_bit) begin
            s_nxt.bitcnt = 3'h0;
            if (external_clk && is_rx && s_r.pending) begin
              s_nxt.state = ssp_pkg::SSP_IDLE;
            end else begin
              if (is_rx) begin
                s_nxt.bufs[s_r.idx] = mode_four(s_r.mode) ?
                                      {4'h0, sh[7:4]} : sh;
              end
              if (s_r.dummy || (is_rx && !s_r.start)) begin
                s_nxt.state = ssp_pkg::SSP_IDLE;
              end else if (last_word) begin
                s_nxt.irq     = 1'b1;
                s_nxt.pending = 1'b1;
                s_nxt.idx     = 3'h0;
                s_nxt.reload  = 1'b1;
                if (!s_r.start) begin
                  s_nxt.state = ssp_pkg::SSP_IDLE;
                end else if (internal_clk) begin
                  s_nxt.state = ssp_pkg::SSP_STALL;
                end
              end else begin
                s_nxt.idx = s_r.idx + 3'h1;
                if (is_tx) begin
                  s_nxt.shreg = s_r.pre;
                end
              end
            end
          end
        end
      end
      ssp_pkg::SSP_STALL: begin
        // clock parked high while waiting for service
        s_nxt.sck      = 1'b1;
        s_nxt.shifting = 1'b0;
        if (!s_nxt.pending) begin
          s_nxt.state    = ssp_pkg::SSP_SHIFT;
          s_nxt.shifting = 1'b1;
        end
        if (!s_r.start) begin
          s_nxt.state = ssp_pkg::SSP_IDLE;
        end
      end
      default: begin
        s_nxt.state = ssp_pkg::SSP_IDLE;
      end
    endcase

    // abort wins over the state machine, not a same-cycle irq, and drops busy at once
    if (abort) begin
      s_nxt.state    = ssp_pkg::SSP_IDLE;
      s_nxt.busy     = 1'b0;
      s_nxt.shifting = 1'b0;
      s_nxt.sck      = 1'b1;
      s_nxt.pending  = 1'b0;
    end else if (s_nxt.state == ssp_pkg::SSP_IDLE) begin
      s_nxt.busy = 1'b0;
    end

    // a burst-done event beats a same-cycle service
    if (s_nxt.irq) begin
      s_nxt.pending = 1'b1;
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_r          <= '0;
      s_r.start    <= ssp_pkg::CONTROL_ONE_RESET[ssp_pkg::START_POS];
      s_r.count    <= ssp_pkg::CONTROL_TWO_RESET[2:0];
      s_r.state    <= ssp_pkg::SSP_IDLE;
      s_r.waitreq  <= 1'b1;
      s_r.sck      <= 1'b1;
      s_r.sck_prev <= 1'b1;
      s_r.so       <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign avs_readdata       = s_r.rdata;
  assign avs_waitrequest    = s_r.waitreq;
  assign sck_out            = s_r.sck;
  assign sck_oe_n           = !s_r.sck_drive;
  assign so_out             = s_r.so;
  assign serial_done_irq    = s_r.irq;
  assign transfer_busy_flag = s_r.busy;

endmodule // ssp_port

// ===== core/ssp_sync3.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps

// ************************************************************
// pin synchroniser
// ************************************************************
module ssp_sync3 (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic pin_in,
  output logic      level_out
);

  typedef struct packed {
    logic [2:0] stage;
    logic       level;
  } ssp_sync_regs_type;

  ssp_sync_regs_type s_r;
  ssp_sync_regs_type s_nxt;

  // external pulses of two or more cycles always pass the filter
  always_comb begin
    s_nxt       = s_r;
    s_nxt.stage = {s_r.stage[1:0], pin_in};
    if (s_r.stage[1] == s_r.stage[2]) begin
      s_nxt.level = s_r.stage[2];
    end
  end

  // idle pin level is high, so every stage starts high
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_r <= '1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign level_out = s_r.level;

endmodule // ssp_sync3

// ===== tb/ssp_peer.sv
// serial peer model: external clock source, data source and sink
`timescale 1ns/1ps

// ************************************************************
// peer on the clock and data pins
// ************************************************************
module ssp_peer (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       ext_en,
  input  wire logic       sck_wire,
  input  wire logic       so_in,
  input  wire logic [7:0] peer_word,
  output logic            sck_drv,
  output logic            si_out,
  output logic [15:0]     cap
);
  logic [2:0] div;
  logic [2:0] cnt;
  logic       last;

  always_ff @(posedge clk) begin
    last <= sck_wire;
    if (!reset_n) begin
      sck_drv <= 1'h1;
      si_out  <= 1'h1;
      div     <= 3'h0;
      cnt     <= 3'h0;
      cap     <= 16'h0000;
    end else begin
      // phases of 8 cycles; a low phase is never cut short
      if (ext_en || !sck_drv) begin
        div <= div + 3'h1;
        if (div == 3'h7) sck_drv <= ~sck_drv;
      end
      if (last && !sck_wire) begin
        si_out <= peer_word[cnt];
        cnt    <= cnt + 3'h1;
      end
      if (!last && sck_wire) cap <= {so_in, cap[15:1]};
    end
  end
endmodule // ssp_peer

// ===== tb/ssp_port_assertions.sv
// pin-level checks of the serial port
`timescale 1ns/1ps

// ************************************************************
// checker
// ************************************************************
module ssp_port_assertions (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic        avs_waitrequest,
  input  wire logic        sck_out,
  input  wire logic        sck_oe_n,
  input  wire logic        so_out,
  input  wire logic        serial_done_irq,
  input  wire logic        transfer_busy_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  AST_BUS_ANSWER: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered next cycle");
  AST_ABORT_IDLE: assert property (
    avs_write && !avs_waitrequest && avs_byteenable[0] &&
    avs_address == ssp_pkg::ADDR_CONTROL_ONE &&
    avs_writedata[ssp_pkg::ABORT_POS] &&
    !avs_writedata[ssp_pkg::START_POS] |-> ##[1:2] !transfer_busy_flag)
    else $error("abort left busy set");
  AST_IRQ_PULSE: assert property (
    serial_done_irq |=> !serial_done_irq)
    else $error("irq longer than one cycle");
  AST_IRQ_BUSY: assert property (
    serial_done_irq |-> transfer_busy_flag || $past(transfer_busy_flag))
    else $error("irq outside a transfer");
  AST_SO_ON_FALL: assert property (
    $changed(so_out) && transfer_busy_flag && !sck_oe_n |-> !sck_out)
    else $error("data out changed while clock high");
  AST_SCK_IDLE: assert property (
    !transfer_busy_flag && !$past(transfer_busy_flag) && !sck_oe_n
      |-> sck_out)
    else $error("driven clock not high when idle");
  AST_START_HIGH: assert property (
    $rose(transfer_busy_flag) && !sck_oe_n |-> sck_out)
    else $error("clock not high at transfer start");
  AST_LOW_WIDTH: assert property (
    $fell(sck_out) && !sck_oe_n |-> (!sck_out || !transfer_busy_flag)[*8])
    else $error("internal clock low phase too short");
endmodule // ssp_port_assertions

bind ssp_port ssp_port_assertions u_chk (.clk(clk), .reset_n(reset_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_waitrequest(avs_waitrequest), .sck_out(sck_out),
  .sck_oe_n(sck_oe_n), .so_out(so_out), .serial_done_irq(serial_done_irq),
  .transfer_busy_flag(transfer_busy_flag));

// ===== tb/ssp_port_tb.sv
// self-checking bench of the synchronous serial port
`timescale 1ns/1ps

// ************************************************************
// bench top
// ************************************************************
module ssp_port_tb;
  logic        clk           = 1'h0;
  logic        reset_n       = 1'h0;
  logic [5:0]  avs_address   = 6'h00;
  logic        avs_read      = 1'h0;
  logic        avs_write     = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic        ext_en        = 1'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        sck_out;
  logic        sck_oe_n;
  logic        so_out;
  logic        serial_done_irq;
  logic        transfer_busy_flag;
  logic        sck_drv;
  logic        sck_wire;
  logic        si_line;
  logic [15:0] cap;
  int          mismatches    = 0;
  int          total_checks  = 0;
  localparam logic [5:0] C1 = ssp_pkg::ADDR_CONTROL_ONE;
  localparam logic [5:0] BUF0 = ssp_pkg::ADDR_BUFFER_BASE;

  always #50 clk = ~clk;
  // peer side idles high, like a pull-up on the pin
  assign sck_wire = sck_oe_n ? sck_drv : sck_out;

  ssp_port dut (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sck_in(sck_wire), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
    .so_out(so_out), .si_in(si_line), .serial_done_irq(serial_done_irq),
    .transfer_busy_flag(transfer_busy_flag));

  ssp_peer peer (.clk(clk), .reset_n(reset_n), .ext_en(ext_en),
    .sck_wire(sck_wire), .so_in(so_out), .peer_word(8'hB6),
    .sck_drv(sck_drv), .si_out(si_line), .cap(cap));

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string w, input logic [15:0] e,
                     input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic bus(input logic wr_n, input logic [5:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    int n;
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= {24'h000000, d};
    avs_write     <= ~wr_n;
    avs_read      <= wr_n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (n > 20) begin
        $display("[ERR] waitrequest expected 0 seen timeout");
        mismatches++;
        final_report();
      end
    end while (avs_waitrequest !== 1'h0);
    q = avs_readdata[7:0];
    avs_write <= 1'h0;
    avs_read  <= 1'h0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'h0, a, d, q);
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] e, string w);
    logic [7:0] q;
    bus(1'h1, a, 8'h00, q);
    chk(w, {8'h00, e}, {8'h00, q});
  endtask

  function automatic logic pick(input int k);
    case (k)
      0: return serial_done_irq;
      1: return transfer_busy_flag;
      default: return sck_out;
    endcase
  endfunction

  task automatic wait_for(input int k, input logic v, input int lim,
                          input string w);
    int n;
    n = 0;
    while (pick(k) !== v) begin
      @(posedge clk);
      #1;
      n++;
      if (n > lim) begin
        $display("[ERR] %s expected %h seen timeout", w, v);
        mismatches++;
        final_report();
      end
    end
  endtask

  // the stalled clock must not move while software is late
  task automatic hold_high(input int lim);
    int bad;
    bad = 0;
    repeat (lim) begin
      @(posedge clk);
      if (sck_out !== 1'h1) bad++;
    end
    chk("stalled sck", 16'h0000, 16'(bad));
  endtask

  task automatic t_reset();
    chk("reset pins", 16'h0006, {11'h000, transfer_busy_flag,
      serial_done_irq, sck_out, so_out, sck_oe_n});
    rd(C1, ssp_pkg::CONTROL_ONE_RESET, "control one");
    rd(ssp_pkg::ADDR_CONTROL_TWO, ssp_pkg::CONTROL_TWO_RESET, "control two");
    rd(ssp_pkg::ADDR_STATUS, 8'h00, "status");
    rd(6'h10, 8'h00, "unmapped");
  endtask

  task automatic t_reserved();
    wr(C1, 8'h86);
    repeat (20) @(posedge clk);
    #1;
    chk("reserved busy", 16'h0000, {15'h0, transfer_busy_flag});
    chk("reserved oe_n", 16'h0001, {15'h0, sck_oe_n});
    wr(C1, 8'h06);
  endtask

  task automatic t_rx();
    wr(ssp_pkg::ADDR_CONTROL_TWO, 8'h00);
    wr(C1, 8'hB5);
    wait_for(0, 1'h1, 300, "rx irq");
    hold_high(40);
    rd(BUF0 + 6'h1C, 8'h00, "unused buffer");
    wait_for(2, 1'h0, 30, "rx release");
    rd(BUF0, 8'h06, "rx nibble");
    wr(C1, 8'h75);
    wait_for(1, 1'h0, 3, "abort busy");
    wr(C1, 8'h05);
    rd(BUF0, 8'h00, "mode clear");
  endtask

  task automatic t_tx();
    wr(BUF0, 8'hA5);
    wr(BUF0 + 6'h04, 8'h3C);
    wr(ssp_pkg::ADDR_CONTROL_TWO, 8'h01);
    wr(C1, 8'h85);
    rd(ssp_pkg::ADDR_STATUS, 8'hC0, "run status");
    wait_for(0, 1'h1, 400, "tx irq");
    hold_high(40);
    rd(ssp_pkg::ADDR_STATUS, 8'h80, "stall status");
    chk("tx bits", 16'h3CA5, cap);
    wr(BUF0 + 6'h1C, 8'h00);
    wait_for(2, 1'h0, 30, "tx release");
    wr(C1, 8'h05);
    wait_for(1, 1'h0, 600, "tx stop");
  endtask

  task automatic t_ext();
    wr(C1, 8'h07);
    wr(BUF0, 8'hC3);
    wr(ssp_pkg::ADDR_CONTROL_TWO, 8'h00);
    wr(C1, 8'h87);
    ext_en <= 1'h1;
    wait_for(0, 1'h1, 600, "ext irq");
    wait_for(1, 1'h0, 600, "ext stop");
    ext_en <= 1'h0;
    chk("ext bits", 16'hFFC3, cap);
  endtask

  // four-bit transmit: only the low nibble leaves, then stop from stall
  task automatic t_tx4();
    wr(C1, 8'h0C);
    wr(BUF0, 8'h5A);
    wr(ssp_pkg::ADDR_CONTROL_TWO, 8'h00);
    wr(C1, 8'h8C);
    wait_for(0, 1'h1, 400, "tx4 irq");
    rd(ssp_pkg::ADDR_STATUS, 8'h80, "tx4 stall");
    chk("tx4 nibble", 16'h000A, {12'h000, cap[15:12]});
    wr(C1, 8'h0C);
    wait_for(1, 1'h0, 10, "tx4 stop");
  endtask

  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'h1;
    @(posedge clk);
    #1;
    t_reset();
    t_reserved();
    t_rx();
    t_tx();
    t_ext();
    t_tx4();
    final_report();
  end
endmodule // ssp_port_tb
